// [param_port_pkg.sv]
// Package with timing constants and carriers for the parameter port block.
package param_port_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PORT_WIDTH = 4;
  // Reset and delete value of the output register (all ones).
  localparam logic [3:0] PARAM_RESET_VALUE = 4'hf;
  // Lead of output data before the strobe falls, design target 500 ns.
  localparam int unsigned LOW_DATA_LEAD_TIME_NS = 500;
  localparam int unsigned LEAD_CYC = LOW_DATA_LEAD_TIME_NS / CLK_PERIOD_NS;
  // Strobe width, least 5000 ns rounded up.
  localparam int unsigned PARAM_STROBE_WIDTH_NS = 5000;
  localparam int unsigned STROBE_CYC =
    (PARAM_STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Driver release after strobe rises in multiplex mode, design 500 ns.
  localparam int unsigned RELEASE_AFTER_STROBE_TIME_NS = 500;
  localparam int unsigned HOLD_CYC = RELEASE_AFTER_STROBE_TIME_NS / CLK_PERIOD_NS;
  // Input sampling instant after new data, 12000 ns inside the 11 to 13.5 us window.
  localparam int unsigned PARAM_INPUT_SAMPLE_DELAY_NS = 12000;
  localparam int unsigned SAMPLE_CYC = PARAM_INPUT_SAMPLE_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 10;

  // Request from the protocol side.
  typedef struct packed {
    logic       write;
    logic       clear;
    logic [3:0] value;
  } param_req_t;

  // Answer to the protocol side.
  typedef struct packed {
    logic       valid;
    logic [3:0] value;
  } param_rsp_t;
endpackage

// [pin_sync.sv]
// Three-stage pin synchroniser, accepting a change once stages two and three agree.
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Shift chain; the filtered level moves only when the last two stages agree.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_r    <= '1;
      s2_r    <= '1;
      s3_r    <= '1;
      level_o <= '1;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // pin_sync

// [param_port.sv]
// Slave-mode parameter port: output register, open-drain drivers, strobe and sampling.
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: Each parameter pin is always both an open-drain pull-down and a sampled input.
// RULE2: A received value is latched in the output register and driven from there.
// RULE3: Inputs are sampled between 11 us and 13.5 us after new data reaches the pins.
// RULE4: Without multiplex the sample is output AND pin; with multiplex it is the pin alone.
// RULE5: Each new value is announced by a low strobe of 5 to 6 us.
// RULE6: Low output bits are valid 0.1 to 0.6 us before the strobe falls, 0.5 us targeted.
// RULE7: High output bits are released 0.1 to 0.6 us before the strobe falls.
// RULE8: In multiplex mode all drivers are off from 0.1 to 0.6 us after the strobe rises.
// RULE9: The first output event after reset unlocks the data port; here only a write unlocks it, the reset strobe does not.
// RULE10: Reset or address delete loads all ones, releases drivers and issues a normal strobe.
// RULE11: In multiplex mode drivers switch off after the strobe and before sampling.
// RULE12: The outside party reads during the strobe and drives its answer right after it.
// RULE13: The outside party holds the inputs stable through the sampling window.
// RULE14: Multiplex mode is selected by a configuration flag at one, zero being compatible.
// RULE15: The data-port block flag clears while a parameter write is processed.
// RULE16: The sampled value is returned as the answer to the causing parameter write.
module param_port (
  input  wire logic                       sys_clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       mux_mode_i,
  input  wire param_port_pkg::param_req_t req_i,
  output logic                            busy_o,
  output param_port_pkg::param_rsp_t      rsp_o,
  output logic                            data_port_unlock_o,
  input  wire logic [3:0]                 param_pin_i,
  output logic [3:0]                      param_pin_o,
  output logic [3:0]                      param_pin_oe_o,
  input  wire logic                       param_strobe_pin_i,
  output logic                            param_strobe_pin_o,
  output logic                            param_strobe_pin_oe_o
);
  typedef enum logic [2:0] {IDLE, LEAD, STROBE, AFTER, WAIT} state_t;

  state_t                            state_r;
  state_t                            state_nxt;
  logic [param_port_pkg::CNT_W-1:0]  cnt_r;
  logic [param_port_pkg::CNT_W-1:0]  since_r;
  logic [3:0]                        out_reg_r;
  logic                              pend_r;
  logic                              pend_clear_r;
  logic [3:0]                        pend_val_r;
  logic                              is_write_r;
  logic                              drive_en_r;
  logic [3:0]                        pin_level;
  logic [3:0]                        sample_val;
  logic                              start;
  logic                              cnt_done;
  logic [param_port_pkg::CNT_W-1:0]  cnt_load;
  logic [param_port_pkg::CNT_W-1:0]  strobe_len_r;

  // Pin inputs pass the three-stage synchroniser.
  pin_sync #(.WIDTH(param_port_pkg::PORT_WIDTH)) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (param_pin_i),
    .level_o   (pin_level)
  );

  // Open-drain drivers pull low only for zero bits while driving is allowed.
  assign param_pin_o    = 4'h0; // RULE1
  assign param_pin_oe_o = drive_en_r ? ~out_reg_r : 4'h0; // RULE2 RULE6 RULE7
  assign param_strobe_pin_o    = 1'b0;
  assign param_strobe_pin_oe_o = (state_r == STROBE); // RULE5
  assign sample_val = mux_mode_i ? pin_level : (pin_level & out_reg_r); // RULE4 RULE14
  assign busy_o     = pend_r;
  assign start      = pend_r && (state_r == IDLE);
  assign cnt_done   = (cnt_r == '0);

  // Next state of the strobe sequence and the length of each phase.
  always_comb begin
    state_nxt = state_r;
    cnt_load  = cnt_r;
    case (state_r)
      IDLE: begin
        if (start) begin
          state_nxt = LEAD;
          cnt_load  = param_port_pkg::CNT_W'(param_port_pkg::LEAD_CYC - 1);
        end
      end
      LEAD: begin
        if (cnt_done) begin
          state_nxt = STROBE;
          cnt_load  = param_port_pkg::CNT_W'(param_port_pkg::STROBE_CYC - 1);
        end
      end
      STROBE: begin
        if (cnt_done) begin
          state_nxt = AFTER;
          cnt_load  = param_port_pkg::CNT_W'(param_port_pkg::HOLD_CYC - 1);
        end
      end
      AFTER: begin
        if (cnt_done) begin
          state_nxt = WAIT;
        end
      end
      WAIT: begin
        if (since_r == param_port_pkg::CNT_W'(param_port_pkg::SAMPLE_CYC)) begin
          state_nxt = IDLE;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  // State and phase counter.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? cnt_load : (cnt_done ? cnt_r : cnt_r - 1'b1);
    end
  end

  // Time since new data reached the pins, which times the input sample.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_r <= '0;
    end else if (start) begin
      since_r <= '0;
    end else if (state_r != IDLE) begin
      since_r <= since_r + 1'b1; // RULE3
    end
  end

  // Pending request; reset itself queues a delete-style update with a strobe.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_r       <= 1'b1; // RULE10
      pend_clear_r <= 1'b1;
      pend_val_r   <= param_port_pkg::PARAM_RESET_VALUE;
    end else if (!pend_r && (req_i.write || req_i.clear)) begin
      pend_r       <= 1'b1;
      pend_clear_r <= req_i.clear;
      pend_val_r   <= req_i.clear ? param_port_pkg::PARAM_RESET_VALUE : req_i.value;
    end else if (start) begin
      pend_r <= 1'b0;
    end
  end

  // Output register, driver enable and write tracking.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_reg_r  <= param_port_pkg::PARAM_RESET_VALUE; // RULE10
      drive_en_r <= 1'b0;
      is_write_r <= 1'b0;
    end else if (start) begin
      out_reg_r  <= pend_val_r; // RULE2
      drive_en_r <= !pend_clear_r; // RULE10
      is_write_r <= !pend_clear_r;
    end else if (state_r == AFTER && cnt_done && mux_mode_i) begin
      drive_en_r <= 1'b0; // RULE8 RULE11
    end
  end

  // Answer with the sampled inputs, and data port unlock on a processed write.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_o              <= '0;
      data_port_unlock_o <= 1'b0;
    end else begin
      rsp_o.valid <= 1'b0;
      if (state_r == WAIT && state_nxt == IDLE) begin
        rsp_o.valid <= is_write_r; // RULE16
        rsp_o.value <= sample_val; // RULE3
      end
      if (start && !pend_clear_r) begin
        data_port_unlock_o <= 1'b1; // RULE9 RULE15
      end else if (start) begin
        data_port_unlock_o <= 1'b0;
      end
    end
  end

  // Helper count of strobe cycles, so the full width can be checked where the strobe ends.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strobe_len_r <= '0;
    end else if (param_strobe_pin_oe_o) begin
      strobe_len_r <= strobe_len_r + 1'b1;
    end else begin
      strobe_len_r <= '0;
    end
  end

  // Lead phase is exact, so low data precedes the strobe by the design target.
  lead_time_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE6
    $rose(param_strobe_pin_oe_o) |->
      ($past(state_r, 26) == IDLE) && ($past(state_r, 25) == LEAD))
    else $error("strobe lead time wrong");

  // Strobe lasts the full width, counted cycle by cycle.
  strobe_width_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE5
    $fell(param_strobe_pin_oe_o) |->
      strobe_len_r == param_port_pkg::CNT_W'(param_port_pkg::STROBE_CYC))
    else $error("strobe width wrong");

  // Driver pattern follows the register while driving.
  drive_pat_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    drive_en_r |-> param_pin_oe_o == ~out_reg_r) // RULE7
    else $error("driver pattern wrong");

  // Multiplex mode has drivers off before sampling.
  mux_release_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (mux_mode_i && state_r == WAIT) |-> param_pin_oe_o == 4'h0) // RULE8
    else $error("drivers on in multiplex wait");

  // Response comes out at the sampling instant.
  sample_time_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE3
    rsp_o.valid |-> $past(since_r) == param_port_pkg::CNT_W'(param_port_pkg::SAMPLE_CYC))
    else $error("sample time wrong");

  // The two kinds of update start: a write drives the new value, a delete loads all ones.
  sequence start_write_s;
    start && !pend_clear_r;
  endsequence

  sequence start_clear_s;
    start && pend_clear_r;
  endsequence

  // A processed write unlocks the data port on the next cycle.
  unlock_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE9
    start_write_s |=> data_port_unlock_o)
    else $error("data port not unlocked");

  // Reset and delete fill the register with ones and leave every driver released.
  delete_release_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE10
    start_clear_s |=>
      (out_reg_r == param_port_pkg::PARAM_RESET_VALUE) && (param_pin_oe_o == 4'h0))
    else $error("delete did not release drivers");
endmodule // param_port

// [param_ext_model.sv]
// Outside logic on the parameter pins, with pull-ups on the open-drain lines.
`timescale 1ns/10ps
module param_ext_model (
  input  wire logic       mux_mode_i,
  input  wire logic       strobe_oe_i,
  input  wire logic [3:0] ret_val_i,
  input  wire logic [3:0] pin_oe_i,
  output logic      [3:0] pin_level_o
);
  logic [3:0] ext_drive;
  // In multiplex mode the outside logic lets go while the strobe is low and answers after it.
  assign ext_drive = (mux_mode_i && strobe_oe_i) ? 4'hf : ret_val_i;
  // A pin is low if either party pulls it; a released pin floats high.
  assign pin_level_o = ext_drive & ~pin_oe_i;
endmodule // param_ext_model

// [tb_parameter_port_strobe.sv]
// Self-checking bench for the parameter port against a reference model.
`timescale 1ns/10ps
module tb_parameter_port_strobe;
  logic                       sys_clk_i;
  logic                       reset_n_i;
  logic                       mux_mode_i;
  logic                       busy_o;
  logic                       unlock;
  logic                       strobe_oe;
  logic [3:0]                 pin_level;
  logic [3:0]                 pin_oe;
  logic [3:0]                 ret_val;
  logic [3:0]                 v;
  param_port_pkg::param_req_t req_i;
  param_port_pkg::param_rsp_t rsp_o;
  int                         failures;
  int                         checked;
  int                         seed;
  logic [3:0]                 exp_q[$];

  param_port dut (
    .sys_clk_i            (sys_clk_i),
    .reset_n_i            (reset_n_i),
    .mux_mode_i           (mux_mode_i),
    .req_i                (req_i),
    .busy_o               (busy_o),
    .rsp_o                (rsp_o),
    .data_port_unlock_o   (unlock),
    .param_pin_i          (pin_level),
    .param_pin_o          (),
    .param_pin_oe_o       (pin_oe),
    .param_strobe_pin_i   (!strobe_oe),
    .param_strobe_pin_o   (),
    .param_strobe_pin_oe_o(strobe_oe)
  );

  param_ext_model ext (
    .mux_mode_i (mux_mode_i),
    .strobe_oe_i(strobe_oe),
    .ret_val_i  (ret_val),
    .pin_oe_i   (pin_oe),
    .pin_level_o(pin_level)
  );

  task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One update sequence: optional request, then strobe, driver and answer timing.
  task automatic run(input logic snd, input logic clr, input logic [3:0] val);
    int n;
    int t_up;
    int t_dn;
    int t_rsp;
    logic [3:0] got;
    n = 0;
    t_up = 0;
    t_dn = 0;
    t_rsp = 0;
    got = 4'h0;
    if (snd) begin
      @(posedge sys_clk_i);
      while (busy_o !== 1'b0 && n < 900) begin
        @(posedge sys_clk_i);
        n++;
      end
      // Model: multiplex returns the outside value alone, otherwise it is wired-AND.
      if (!clr) exp_q.push_back(mux_mode_i ? ret_val : (val & ret_val));
      req_i <= '{write: !clr, clear: clr, value: val};
      @(posedge sys_clk_i);
      req_i <= '0;
    end
    // Outputs are looked at on the falling edge, well clear of the edge that launches them.
    for (n = 1; n < 720; n++) begin
      @(negedge sys_clk_i);
      if (strobe_oe === 1'b1 && t_up == 0) begin
        t_up = n;
        check_val(pin_oe, ~val);
      end
      if (strobe_oe === 1'b0 && t_up != 0 && t_dn == 0) t_dn = n;
      if (t_dn != 0 && n == t_dn + 31) check_val(pin_oe, mux_mode_i ? 4'h0 : ~val);
      if (rsp_o.valid === 1'b1) begin
        t_rsp = n;
        got = rsp_o.value;
      end
    end
    if (snd) check_rng(t_up, 7, 32);
    check_rng(t_dn - t_up, 250, 300);
    check_val({3'h0, unlock}, {3'h0, !clr});
    if (clr) begin
      check_rng(t_rsp, 0, 0);
    end else begin
      check_rng(t_rsp, 552, 677);
      check_val(got, exp_q.pop_front());
    end
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Watchdog sized for eleven sequences of some 720 cycles each.
  initial begin
    #400000;
    failures++;
    wrap_up();
  end

  // Reset, the reset strobe, then writes and a delete in both port modes.
  initial begin
    failures = 0;
    checked = 0;
    seed = 12;
    reset_n_i = 1'b0;
    mux_mode_i = 1'b0;
    req_i = '0;
    ret_val = 4'ha;
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    run(1'b0, 1'b1, 4'hf);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 5; i++) begin
        v = (i == 0) ? 4'h0 : (i == 1 || i == 4) ? 4'hf : 4'($random(seed));
        @(posedge sys_clk_i);
        mux_mode_i <= m[0];
        ret_val <= 4'($random(seed));
        run(1'b1, i == 4, v);
      end
    end
    wrap_up();
  end
endmodule // tb_parameter_port_strobe
